// *** shared/ref_mon_map.vh ***
// Constants for reference monitoring and DPLL state control
`ifndef REF_MON_MAP_VH
`define REF_MON_MAP_VH
// Clock rate in kHz (125 MHz core clock)
`define CLK_KHZ 125000
// Disqualify times in ms; minimum time in core clock cycles
`define DQ_T1_MS 10
`define DQ_T2_MS 50
`define DQ_T3_MS 2500
`define DQ_MIN_CYC 1
// Disqualify setting reset value, requalify factor reset value
`define DQ_SEL_RST 2'h2
`define RQ_SEL_RST 2'h1
// Requalify multipliers as shift amounts (2,4,16,32)
`define RQ_SH0 1
`define RQ_SH1 2
`define RQ_SH2 4
`define RQ_SH3 5
// Mask bit positions and mask reset value
`define MB_LOS 0
`define MB_SCM 1
`define MB_CFM 2
`define MB_GST 3
`define MASK_RST 4'hF
// Frequency window: count ref edges in 2^17 clocks, 0.1% window
`define FWIN_CYC 131072
`define FTOL_DIV 20'h003E8
// Single-cycle period tolerance (quarter of period) and absence limit
`define SC_TOL_SH 2
`define SC_MAX_CYC 20'hFFFFF
// Lock time in ms and phase detector lock threshold
`define LOCK_MS 1000
`define LOCK_TOL 16'h0010
// DPLL states
`define ST_FREE 2'h0
`define ST_NORM 2'h1
`define ST_HOLD 2'h2
`endif

// *** rtl/ref_monitor.v ***
// Per-reference frequency, single-cycle monitors and soak timer
`timescale 1ns/1ns
`include "ref_mon_map.vh"
module ref_monitor (
    // Clock and reset
    input wire core_clk,
    input wire arst_n,
    input wire clkEn,
    // Reference and configuration
    input wire refIn,
    input wire [19:0] nomCount,
    input wire [19:0] nomPeriod,
    input wire [1:0] dqSel,
    input wire [1:0] rqSel,
    // Failures
    output reg freqFail_r,
    output reg cycFail_r,
    output reg soakFail_r
);
    localparam [31:0] DQ1 = `DQ_T1_MS * `CLK_KHZ;
    localparam [31:0] DQ2 = `DQ_T2_MS * `CLK_KHZ;
    localparam [31:0] DQ3 = `DQ_T3_MS * `CLK_KHZ;
    reg s1_r, s2_r, s3_r;
    reg [16:0] winCnt_r;
    reg [19:0] edgeCnt_r, perCnt_r;
    reg [36:0] soakCnt_r;
    reg [31:0] dqCyc;
    reg [36:0] rqCyc;
    wire rise = s2_r & ~s3_r;
    wire [19:0] ftol = nomCount / `FTOL_DIV;
    wire [19:0] ptol = nomPeriod >> `SC_TOL_SH;
    wire anyFail = freqFail_r | cycFail_r;
    // Decode soak times
    always @* begin
        case (dqSel)
            2'h0: dqCyc = `DQ_MIN_CYC;
            2'h1: dqCyc = DQ1;
            2'h2: dqCyc = DQ2;
            default: dqCyc = DQ3;
        endcase
        case (rqSel)
            2'h0: rqCyc = {5'h00, dqCyc} << `RQ_SH0;
            2'h1: rqCyc = {5'h00, dqCyc} << `RQ_SH1;
            2'h2: rqCyc = {5'h00, dqCyc} << `RQ_SH2;
            default: rqCyc = {5'h00, dqCyc} << `RQ_SH3;
        endcase
    end
    // Synchroniser, monitors and soak timer; private per reference
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= 1'b0; s2_r <= 1'b0; s3_r <= 1'b0;
            winCnt_r <= 17'h00000; edgeCnt_r <= 20'h00000; perCnt_r <= 20'h00000;
            freqFail_r <= 1'b1; cycFail_r <= 1'b1; soakFail_r <= 1'b1;
            soakCnt_r <= 37'h0000000000;
        end else if (clkEn) begin
            s1_r <= refIn; s2_r <= s1_r; s3_r <= s2_r;
            // Count edges over short window, compare to nominal +/-0.1%
            winCnt_r <= winCnt_r + 17'h00001;
            if (winCnt_r == 17'h1FFFF) begin
                freqFail_r <= (edgeCnt_r > nomCount + ftol) ||
                              (edgeCnt_r + ftol < nomCount); // R3
                edgeCnt_r <= {19'h00000, rise};
            end else if (rise)
                edgeCnt_r <= edgeCnt_r + 20'h00001;
            // Period of each cycle; phase hit or missing edges
            if (rise) begin
                perCnt_r <= 20'h00001;
                cycFail_r <= (perCnt_r > nomPeriod + ptol) ||
                             (perCnt_r + ptol < nomPeriod); // R4
            end else if (perCnt_r > nomPeriod + ptol) begin
                cycFail_r <= 1'b1; // R4
                if (perCnt_r != `SC_MAX_CYC) perCnt_r <= perCnt_r + 20'h00001;
            end else
                perCnt_r <= perCnt_r + 20'h00001;
            // Disqualify after dq time, requalify after longer time
            if (anyFail != soakFail_r) begin
                if ((anyFail && soakCnt_r + 37'h1 >= {5'h00, dqCyc}) ||
                    (!anyFail && soakCnt_r + 37'h1 >= rqCyc)) begin // R5 R7 R8
                    soakFail_r <= anyFail;
                    soakCnt_r <= 37'h0000000000;
                end else
                    soakCnt_r <= soakCnt_r + 37'h0000000001;
            end else
                soakCnt_r <= 37'h0000000000; // R8
        end
    end
endmodule

// *** rtl/dpll_ctrl.v ***
// DPLL state machine, holdover storage, rate conversion
`timescale 1ns/1ns
`include "ref_mon_map.vh"
module dpll_ctrl (
    // Clock and reset
    input wire core_clk,
    input wire arst_n,
    input wire clkEn,
    // Control
    input wire forceHold,
    input wire forceFree,
    input wire holdTrig,
    input wire refValid,
    input wire signed [15:0] phaseErr,
    input wire [2:0] bwSel,
    input wire [1:0] pullSel,
    input wire [1:0] slopeSel,
    input wire [15:0] fwdDiv,
    input wire [15:0] fbDiv,
    input wire [15:0] fecFwdDiv,
    input wire [15:0] fecFbDiv,
    input wire fecEn,
    // Status, frequency word and divider outputs
    output reg [1:0] state_r,
    output reg locked_r,
    output reg signed [31:0] freqWord_r,
    output reg [15:0] fwdOut_r,
    output reg [15:0] fbOut_r
);
    localparam [31:0] LOCK_CYC = `LOCK_MS * `CLK_KHZ;
    reg signed [31:0] holdWord_r;
    reg [31:0] lockCnt_r;
    reg [2:0] bw;
    reg signed [31:0] step, lim;
    reg signed [31:0] nxtWord;
    wire inLock = (phaseErr < $signed(`LOCK_TOL)) && (phaseErr > -$signed(`LOCK_TOL));
    // Filter gain, pull-in limit, slope limit
    always @* begin
        bw = (bwSel > 3'h6) ? 3'h6 : bwSel; // R14
        // Signed cast keeps the right shift arithmetic for negative errors
        step = ($signed({{16{phaseErr[15]}}, phaseErr}) <<< bw) >>> 4;
        case (slopeSel) // R17
            2'h0: step = (step > 32'sd4096) ? 32'sd4096 :
                         (step < -32'sd4096) ? -32'sd4096 : step;
            2'h1: step = (step > 32'sd512) ? 32'sd512 :
                         (step < -32'sd512) ? -32'sd512 : step;
            2'h2: step = (step > 32'sd60) ? 32'sd60 : (step < -32'sd60) ? -32'sd60 : step;
            default: step = step;
        endcase
        case (pullSel) // R13
            2'h0: lim = 32'sd52 <<< 12;
            2'h1: lim = 32'sd130 <<< 12;
            2'h2: lim = 32'sd400 <<< 12;
            default: lim = 32'sd3900 <<< 12;
        endcase
        nxtWord = freqWord_r + step;
        if (nxtWord > lim) nxtWord = lim;
        if (nxtWord < -lim) nxtWord = -lim;
    end
    // State machine
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= `ST_FREE; locked_r <= 1'b0;
            freqWord_r <= 32'sh00000000; holdWord_r <= 32'sh00000000;
            lockCnt_r <= 32'h00000000;
            fwdOut_r <= 16'h0001; fbOut_r <= 16'h0001;
        end else if (clkEn) begin
            fwdOut_r <= fecEn ? fecFwdDiv : fwdDiv; // R22
            fbOut_r <= fecEn ? fecFbDiv : fbDiv; // R22
            case (state_r)
                `ST_FREE: begin
                    freqWord_r <= 32'sh00000000; // R20
                    locked_r <= 1'b0;
                    if (!forceFree && !forceHold && refValid) state_r <= `ST_NORM;
                end
                `ST_NORM: begin
                    freqWord_r <= nxtWord;
                    if (inLock && lockCnt_r < LOCK_CYC) lockCnt_r <= lockCnt_r + 32'h1;
                    else if (!inLock) lockCnt_r <= 32'h00000000;
                    locked_r <= inLock && lockCnt_r >= 32'h00000100; // R19
                    if (locked_r) holdWord_r <= freqWord_r; // R21
                    if (forceFree) state_r <= `ST_FREE;
                    else if (forceHold || holdTrig) state_r <= `ST_HOLD; // R11 R21
                end
                default: begin
                    freqWord_r <= holdWord_r; // R21
                    locked_r <= 1'b0;
                    lockCnt_r <= 32'h00000000;
                    if (forceFree) state_r <= `ST_FREE;
                    else if (!forceHold && !holdTrig && refValid) state_r <= `ST_NORM;
                end
            endcase
        end
    end
endmodule

// *** rtl/ref_monitor_dpll_state_ctrl.v ***
// Top: reference qualification, masks, switching and DPLL control
//
// Overview of operation
// R1 - Each reference has its own monitors
// R2 - GPIO may serve as loss-of-signal input
// R3 - Frequency monitor flags deviation over 0.1%
// R4 - Period monitor flags phase hit, missing edges
// R5 - Soak timer disqualifies after persistent failure
// R6 - Disqualify time: minimum, 10ms, 50ms, 2.5s
// R7 - Requalify time is disqualify times 2/4/16/32
// R8 - Longer requalify time gives hysteresis
// R9 - Fail mask gates failures onto fail pin
// R10 - Switch mask gates failures for auto-switching
// R11 - Holdover mask gates failures for auto-holdover
// R12 - Mask bits: LOSS_OF_SIGNAL_IN, cycle, frequency, soak timer
// R13 - Pull-in range 52/130/400/3900 ppm
// R14 - First order bandwidth 14 to 896 Hz
// R15 - Software holds over before bandwidth change
// R16 - Software keeps bandwidth below ref/30
// R17 - Phase slope limit on reference switch
// R18 - Software starts slope limit unlimited
// R19 - Lock and holdover flags, lock under 1s
// R20 - Free-run uses master clock only
// R21 - Holdover uses stored frequency value
// R22 - 16-bit dividers, normal or FEC rate
`timescale 1ns/1ns
`include "ref_mon_map.vh"
module ref_monitor_dpll_state_ctrl (
    // Clock, reset, enable
    input wire core_clk,
    input wire arst_n,
    input wire clkEn,
    // References and GPIO
    input wire refA,
    input wire refB,
    input wire [1:0] gpioIn,
    input wire [1:0] losGpioEn,
    input wire [1:0] losGpioSel,
    // Monitor configuration
    input wire [19:0] nomCountA,
    input wire [19:0] nomCountB,
    input wire [19:0] nomPeriodA,
    input wire [19:0] nomPeriodB,
    input wire dqSelWe,
    input wire [1:0] dqSelIn,
    input wire [1:0] rqSelIn,
    // Masks
    input wire maskWe,
    input wire [3:0] refAFailMaskIn,
    input wire [3:0] refBFailMaskIn,
    input wire [3:0] switchFailMaskIn,
    input wire [3:0] holdoverFailMaskIn,
    // DPLL control
    input wire activeSelIn,
    input wire autoSwitchEn,
    input wire forceHold,
    input wire forceFree,
    input wire signed [15:0] phaseErr,
    input wire [2:0] bwSel,
    input wire [1:0] pullSel,
    input wire [1:0] slopeSel,
    input wire [15:0] fwdDiv,
    input wire [15:0] fbDiv,
    input wire [15:0] fecFwdDiv,
    input wire [15:0] fecFbDiv,
    input wire fecEn,
    // Status
    output reg [3:0] refAStatus_r,
    output reg [3:0] refBStatus_r,
    output reg refAValid_r,
    output reg refBValid_r,
    output reg activeRef_r,
    output wire lockFlag,
    output wire holdoverFlag,
    output wire [1:0] dpllState,
    output wire signed [31:0] freqWord,
    output wire [15:0] fwdDivOut,
    output wire [15:0] fbDivOut
);
    reg [1:0] dqSel_r, rqSel_r;
    reg [3:0] refAFailMask_r, refBFailMask_r, switchFailMask_r, holdoverFailMask_r;
    reg [1:0] gpS1_r, gpS2_r;
    wire [1:0] refs = {refB, refA};
    wire [1:0] losRaw;
    wire [3:0] stat [0:1];
    wire [39:0] nomC = {nomCountB, nomCountA};
    wire [39:0] nomP = {nomPeriodB, nomPeriodA};
    wire hold;
    wire [1:0] dst;

    // Masked failure is any unmasked active condition
    function maskedFail;
        input [3:0] st;
        input [3:0] m;
        begin
            maskedFail = |(st & m); // R12
        end
    endfunction

    // Configuration held in registers, loaded on write strobes
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dqSel_r <= `DQ_SEL_RST; // R6
            rqSel_r <= `RQ_SEL_RST; // R7
            refAFailMask_r <= `MASK_RST;
            refBFailMask_r <= `MASK_RST;
            switchFailMask_r <= `MASK_RST;
            holdoverFailMask_r <= `MASK_RST;
        end else if (clkEn) begin
            if (dqSelWe) begin
                dqSel_r <= dqSelIn;
                rqSel_r <= rqSelIn;
            end
            if (maskWe) begin
                refAFailMask_r <= refAFailMaskIn;
                refBFailMask_r <= refBFailMaskIn;
                switchFailMask_r <= switchFailMaskIn;
                holdoverFailMask_r <= holdoverFailMaskIn;
            end
        end
    end

    // GPIO pins are asynchronous; two-stage sync before use
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            gpS1_r <= 2'h0;
            gpS2_r <= 2'h0;
        end else if (clkEn) begin
            gpS1_r <= gpioIn;
            gpS2_r <= gpS1_r;
        end
    end

    // Independent monitor set per reference
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gMon
            wire fF, cF, sF;
            ref_monitor uMon ( // R1
                .core_clk(core_clk),
                .arst_n(arst_n),
                .clkEn(clkEn),
                .refIn(refs[g]),
                .nomCount(nomC[g*20 +: 20]),
                .nomPeriod(nomP[g*20 +: 20]),
                .dqSel(dqSel_r),
                .rqSel(rqSel_r),
                .freqFail_r(fF),
                .cycFail_r(cF),
                .soakFail_r(sF)
            );
            // Loss of signal from a selected GPIO when enabled
            assign losRaw[g] = losGpioEn[g] & gpS2_r[losGpioSel[g]]; // R2
            assign stat[g] = {sF, fF, cF, losRaw[g]}; // R12
        end
    endgenerate

    // Status, fail-pin validity and active reference selection
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            refAStatus_r <= 4'h0;
            refBStatus_r <= 4'h0;
            refAValid_r <= 1'b0;
            refBValid_r <= 1'b0;
            activeRef_r <= 1'b0;
        end else if (clkEn) begin
            refAStatus_r <= stat[0];
            refBStatus_r <= stat[1];
            refAValid_r <= !maskedFail(stat[0], refAFailMask_r); // R9 R12
            refBValid_r <= !maskedFail(stat[1], refBFailMask_r); // R9 R12
            // Auto-switch only when the other reference is clean under the same mask; follow activeSelIn only while autoSwitchEn is low
            if (!autoSwitchEn)
                activeRef_r <= activeSelIn;
            else if (maskedFail(stat[activeRef_r], switchFailMask_r) &&
                     !maskedFail(stat[~activeRef_r], switchFailMask_r))
                activeRef_r <= ~activeRef_r; // R10
        end
    end

    // Auto-holdover trigger from the active reference
    assign hold = maskedFail(stat[activeRef_r], holdoverFailMask_r); // R11

    dpll_ctrl uDpll (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .forceHold(forceHold),
        .forceFree(forceFree),
        .holdTrig(hold),
        .refValid(!hold),
        .phaseErr(phaseErr),
        .bwSel(bwSel),
        .pullSel(pullSel),
        .slopeSel(slopeSel),
        .fwdDiv(fwdDiv),
        .fbDiv(fbDiv),
        .fecFwdDiv(fecFwdDiv),
        .fecFbDiv(fecFbDiv),
        .fecEn(fecEn),
        .state_r(dst),
        .locked_r(lockFlag),
        .freqWord_r(freqWord),
        .fwdOut_r(fwdDivOut),
        .fbOut_r(fbDivOut)
    );

    // Indicator flags
    assign holdoverFlag = (dst == `ST_HOLD); // R19
    assign dpllState = dst;
endmodule

// *** verification/phy_model.sv ***
// Upstream line device model: reference clocks and loss-of-signal pins
`timescale 1ns/1ns
module phy_model (
    // Controls from the bench
    input wire [7:0] halfA,
    input wire [7:0] halfB,
    input wire runA,
    input wire runB,
    input wire [1:0] losReq,
    // Pins toward the block
    output logic refA,
    output logic refB,
    output wire [1:0] losOut
);
    // Recovered clocks; parked low while the line is down, never free running
    initial begin
        refA = 1'b0;
        forever #(halfA) refA = runA & ~refA;
    end
    initial begin
        refB = 1'b0;
        forever #(halfB) refB = runB & ~refB;
    end
    // Loss flag held high while the line cannot be recovered
    assign losOut = losReq;
endmodule

// *** verification/rmd_asserts.sv ***
// Concurrent checks on the top-level ports of the reference and DPLL block
`timescale 1ns/1ns
`include "ref_mon_map.vh"
module rmd_asserts (
    // Clock and reset
    input wire core_clk,
    input wire arst_n,
    // Inputs watched
    input wire maskWe,
    input wire [3:0] refAFailMaskIn,
    input wire [1:0] gpioIn,
    input wire [1:0] losGpioEn,
    input wire [1:0] losGpioSel,
    input wire forceHold,
    input wire forceFree,
    input wire signed [15:0] phaseErr,
    input wire fecEn,
    input wire [15:0] fwdDiv,
    // Outputs watched
    input wire [3:0] refAStatus_r,
    input wire refAValid_r,
    input wire lockFlag,
    input wire holdoverFlag,
    input wire [1:0] dpllState,
    input wire signed [31:0] freqWord,
    input wire [15:0] fwdDivOut
);
    reg [3:0] maskA_r;
    reg [8:0] quiet_r;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Shadow mask and quiet-phase run length; the run saturates to stay small
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            maskA_r <= 4'hF;
            quiet_r <= 9'h000;
        end else begin
            if (maskWe) maskA_r <= refAFailMaskIn;
            if (phaseErr <= -16 || phaseErr >= 16) quiet_r <= 9'h000;
            else if (quiet_r != 9'h1FF) quiet_r <= quiet_r + 9'h001;
        end
    end
    sequence s_freeHeld;
        forceFree [*3];
    endsequence
    sequence s_holdHeld;
        (forceHold && !forceFree) [*3];
    endsequence
    sequence s_calm;
        ($stable(refAStatus_r) && !maskWe) [*3];
    endsequence
    property p_losFollow;
        (losGpioEn[0] && !losGpioSel[0] && gpioIn[0]) [*5] |-> refAStatus_r[0];
    endproperty
    a_losFollow: assert property (p_losFollow) else $error("loss flag not seen");
    property p_validMask;
        s_calm |-> refAValid_r == ~|(refAStatus_r & maskA_r);
    endproperty
    a_validMask: assert property (p_validMask) else $error("valid disagrees");
    property p_forceFree;
        s_freeHeld |-> dpllState == `ST_FREE;
    endproperty
    a_forceFree: assert property (p_forceFree) else $error("free-run missed");
    property p_forceHold;
        s_holdHeld |-> dpllState != `ST_NORM;
    endproperty
    a_forceHold: assert property (p_forceHold) else $error("normal while forced");
    property p_holdFlag;
        (holdoverFlag == (dpllState == `ST_HOLD)) &&
            !(holdoverFlag && $past(holdoverFlag) && lockFlag);
    endproperty
    a_holdFlag: assert property (p_holdFlag) else $error("holdover flag wrong");
    property p_lockTime;
        $rose(lockFlag) |-> quiet_r >= 9'h100;
    endproperty
    a_lockTime: assert property (p_lockTime) else $error("lock too early");
    property p_holdWord;
        // Word settles to the stored value one cycle after entry
        dpllState == `ST_HOLD && $past(dpllState) == `ST_HOLD &&
            $past(dpllState, 2) == `ST_HOLD |-> $stable(freqWord);
    endproperty
    a_holdWord: assert property (p_holdWord) else $error("holdover word moved");
    property p_divPass;
        (!fecEn && $stable(fwdDiv)) [*4] |-> fwdDivOut == fwdDiv;
    endproperty
    a_divPass: assert property (p_divPass) else $error("divider wrong");
endmodule
bind ref_monitor_dpll_state_ctrl rmd_asserts u_chk (
    .core_clk, .arst_n, .maskWe, .refAFailMaskIn, .gpioIn, .losGpioEn, .losGpioSel,
    .forceHold, .forceFree, .phaseErr, .fecEn, .fwdDiv, .refAStatus_r, .refAValid_r,
    .lockFlag, .holdoverFlag, .dpllState, .freqWord, .fwdDivOut
);

// *** verification/tb_ref_monitor_dpll_state_ctrl.sv ***
// Self-checking bench for reference qualification and DPLL control
`timescale 1ns/1ns
`include "ref_mon_map.vh"
module tb_ref_monitor_dpll_state_ctrl;
    // Design inputs and outputs
    logic core_clk, arst_n, clkEn, dqSelWe, maskWe, activeSelIn, autoSwitchEn;
    logic forceHold, forceFree, fecEn, runA, runB;
    logic [1:0] losGpioEn, losGpioSel, dqSelIn, rqSelIn, pullSel, slopeSel, losReq;
    logic [19:0] nomCountA, nomCountB, nomPeriodA, nomPeriodB;
    logic [3:0] refAFailMaskIn, refBFailMaskIn, switchFailMaskIn, holdoverFailMaskIn;
    logic signed [15:0] phaseErr;
    logic [2:0] bwSel;
    logic [15:0] fwdDiv, fbDiv, fecFwdDiv, fecFbDiv;
    logic [7:0] halfA, halfB;
    wire refA, refB, refAValid_r, refBValid_r, activeRef_r, lockFlag, holdoverFlag;
    wire [1:0] gpioIn, dpllState;
    wire [3:0] refAStatus_r, refBStatus_r;
    wire signed [31:0] freqWord;
    wire [15:0] fwdDivOut, fbDivOut;
    int miscompares, samples_checked, i;
    ref_monitor_dpll_state_ctrl u_dut (
        .core_clk, .arst_n, .clkEn, .refA, .refB, .gpioIn, .losGpioEn, .losGpioSel,
        .nomCountA, .nomCountB, .nomPeriodA, .nomPeriodB, .dqSelWe, .dqSelIn, .rqSelIn,
        .maskWe, .refAFailMaskIn, .refBFailMaskIn, .switchFailMaskIn, .holdoverFailMaskIn,
        .activeSelIn, .autoSwitchEn, .forceHold, .forceFree, .phaseErr, .bwSel, .pullSel,
        .slopeSel, .fwdDiv, .fbDiv, .fecFwdDiv, .fecFbDiv, .fecEn, .refAStatus_r,
        .refBStatus_r, .refAValid_r, .refBValid_r, .activeRef_r, .lockFlag, .holdoverFlag,
        .dpllState, .freqWord, .fwdDivOut, .fbDivOut
    );
    phy_model u_phy (.halfA, .halfB, .runA, .runB, .losReq, .refA, .refB, .losOut(gpioIn));
    // 125 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Drive just after the edge so the design samples settled inputs
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task masks(input logic [3:0] a, input logic [3:0] b, input logic [3:0] s,
               input logic [3:0] h);
        {refAFailMaskIn, refBFailMaskIn, switchFailMaskIn, holdoverFailMaskIn} = {a, b, s, h};
        maskWe = 1'b1;
        tick(1);
        maskWe = 1'b0;
        tick(1);
    endtask
    task tally_and_finish;
        $display("Checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Looked at while reset is still held
    task t_reset;
        chk(dpllState, `ST_FREE);
        chk({refAValid_r, refBValid_r, lockFlag, holdoverFlag, activeRef_r}, 5'h00);
        chk(freqWord, 32'h0000_0000);
        chk({fwdDivOut, fbDivOut}, 32'h0001_0001);
        chk({refAStatus_r, refBStatus_r}, 8'h00);
        $display("test reset done");
    endtask
    // Loss on A only; B watches the other pin and must stay good
    task t_los;
        masks(4'h1, 4'h1, 4'h0, 4'h0);
        {losGpioEn, losGpioSel, losReq} = 6'h39;
        tick(6);
        chk(refAStatus_r[0], 1'b1);
        chk({refAValid_r, refBValid_r}, 2'h1);
        masks(4'h0, 4'h0, 4'h0, 4'h0);
        chk(refAValid_r, 1'b1);
        losReq = 2'h0;
        $display("test los done");
    endtask
    // Period monitor: good clock, phase hit, then a dead line
    task t_cycle;
        masks(4'h2, 4'h2, 4'h0, 4'h0);
        dqSelWe = 1'b1;
        tick(1);
        dqSelWe = 1'b0;
        runA = 1'b1;
        for (i = 0; i < 300 && refAValid_r !== 1'b1; i++) tick(1);
        chk(refAStatus_r[1], 1'b0);
        chk({refBValid_r, refBStatus_r[1]}, 2'h1);
        chk(refAStatus_r[3:2], 2'h3);
        halfA = 8'h28;
        tick(60);
        chk(refAStatus_r[1], 1'b1);
        halfA = 8'h3F;
        for (i = 0; i < 300 && refAValid_r !== 1'b1; i++) tick(1);
        chk(refAValid_r, 1'b1);
        runA = 1'b0;
        tick(40);
        chk({refAStatus_r[1], refAValid_r}, 2'h2);
        $display("test cycle done");
    endtask
    // State machine: normal, lock, holdover with retuning, free-run
    task t_states;
        masks(4'h0, 4'h0, 4'h0, 4'h0);
        chk(dpllState, `ST_NORM);
        // Large negative error: out of lock, word driven to the low range limit
        phaseErr = -16'sh0100;
        tick(300);
        chk(lockFlag, 1'b0);
        chk(freqWord, 32'hFFFC_C000);
        phaseErr = 16'sh0000;
        for (i = 0; i < 400 && lockFlag !== 1'b1; i++) tick(1);
        chk(lockFlag, 1'b1);
        forceHold = 1'b1;
        tick(3);
        chk({dpllState, holdoverFlag}, {`ST_HOLD, 1'b1});
        chk(freqWord, 32'hFFFC_C000);
        // Error during holdover must not move the stored word
        phaseErr = 16'sh0100;
        // Retuned only in holdover; slope set unlimited before leaving it
        for (i = 0; i < 7; i++) begin
            {bwSel, pullSel, slopeSel} = {i[2:0], i[1:0], i[1:0]};
            tick(2);
        end
        chk(dpllState, `ST_HOLD);
        chk(freqWord, 32'hFFFC_C000);
        slopeSel = 2'h3;
        forceHold = 1'b0;
        tick(3);
        chk(dpllState, `ST_NORM);
        forceFree = 1'b1;
        tick(3);
        chk(dpllState, `ST_FREE);
        chk(freqWord, 32'h0000_0000);
        forceFree = 1'b0;
        phaseErr = 16'sh0000;
        tick(4);
        $display("test states done");
    endtask
    // Holdover mask then switch mask on the active reference
    task t_auto;
        masks(4'h0, 4'h0, 4'h0, 4'h1);
        losReq = 2'h1;
        tick(8);
        chk(dpllState, `ST_HOLD);
        losReq = 2'h0;
        tick(8);
        chk(dpllState, `ST_NORM);
        masks(4'h0, 4'h0, 4'h1, 4'h0);
        autoSwitchEn = 1'b1;
        losReq = 2'h1;
        tick(8);
        chk(activeRef_r, 1'b1);
        {autoSwitchEn, losReq} = 3'h0;
        tick(4);
        chk(activeRef_r, 1'b0);
        $display("test auto done");
    endtask
    // Divider pair selection in both directions
    task t_div;
        chk({fwdDivOut, fbDivOut}, {fwdDiv, fbDiv});
        // Enable low freezes the divider outputs
        clkEn = 1'b0;
        fecEn = 1'b1;
        tick(4);
        chk({fwdDivOut, fbDivOut}, 32'h0123_0456);
        clkEn = 1'b1;
        tick(4);
        chk({fwdDivOut, fbDivOut}, 32'h00FF_00EE);
        fecEn = 1'b0;
        tick(4);
        chk({fwdDivOut, fbDivOut}, 32'h0123_0456);
        $display("test div done");
    endtask
    initial begin
        {clkEn, arst_n, dqSelWe, maskWe, activeSelIn, autoSwitchEn} = 6'h20;
        {forceHold, forceFree, fecEn, runA, runB} = 5'h00;
        {losGpioEn, losGpioSel, dqSelIn, rqSelIn, losReq} = 10'h000;
        {nomCountA, nomCountB, nomPeriodA, nomPeriodB} = 80'h02000_02000_00010_00010;
        {halfA, halfB} = 16'h3F41;
        {bwSel, pullSel, slopeSel, phaseErr} = 23'h630000;
        {fwdDiv, fbDiv, fecFwdDiv, fecFbDiv} = 64'h0123_0456_00FF_00EE;
        {refAFailMaskIn, refBFailMaskIn, switchFailMaskIn, holdoverFailMaskIn} = 16'hFFFF;
        tick(2);
        t_reset;
        tick(2);
        arst_n = 1'b1;
        t_los;
        t_cycle;
        t_states;
        t_auto;
        t_div;
        tally_and_finish;
    end
    // Watchdog: tests need under two thousand cycles
    initial begin
        #200000;
        miscompares++;
        tally_and_finish;
    end
endmodule
